// ===== src/occ_pkg.sv
package occ_pkg;

    // register byte addresses
    localparam logic [7:0] OCC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] OCC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] OCC_ADDR_MASK = 8'h08;

    // control register field positions
    localparam int OCC_BIT_IDLE_STOP = 13;
    localparam int OCC_BIT_FAULT_FLAG = 4;
    localparam int OCC_BIT_TSEL = 3;
    localparam int OCC_MODE_LSB = 0;

    // status and mask field positions
    localparam int OCC_ST_EDGE = 0;
    localparam int OCC_ST_FAULT = 1;
    localparam int OCC_ST_WIDTH = 2;

    // reset values
    localparam logic [1:0] OCC_MASK_RESET = 2'h0;
    localparam logic [15:0] OCC_COUNT_ZERO = 16'h0000;

    // channels that may raise a dma trigger
    localparam int OCC_DMA_CH_FIRST = 1;
    localparam int OCC_DMA_CH_LAST = 2;

    typedef enum logic [2:0] {
        OCC_MODE_OFF = 3'h0,
        OCC_MODE_SET_HIGH = 3'h1,
        OCC_MODE_SET_LOW = 3'h2,
        OCC_MODE_TOGGLE = 3'h3,
        OCC_MODE_SINGLE_PULSE = 3'h4,
        OCC_MODE_CONT_PULSE = 3'h5,
        OCC_MODE_PWM = 3'h6,
        OCC_MODE_PWM_FAULT = 3'h7
    } occ_mode_t;

    // pulse sequencer for the dual compare modes
    typedef enum logic [2:0] {
        OCC_PS_ARM = 3'h1,
        OCC_PS_HIGH = 3'h2,
        OCC_PS_DONE = 3'h4
    } occ_pulse_t;

    typedef struct packed {
        logic idle_stop;
        logic fault_flag;
        logic timebase_select;
        occ_mode_t compare_mode;
    } occ_ctrl_t;

    typedef struct packed {
        logic [15:0] timebase_a;
        logic [15:0] timebase_b;
        logic [15:0] primary_compare_value;
        logic [15:0] secondary_compare_value;
    } occ_timing_t;

endpackage : occ_pkg

// ===== src/occ_sync.sv
`timescale 1ns/10ps
module occ_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // asynchronous level in, synchronised level out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // stage1 feeds only sync_out to keep metastability contained
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : occ_sync

// ===== src/occ_channel.sv
`timescale 1ns/10ps
module occ_channel
    import occ_pkg::*;
#(
    parameter int CHANNEL_INDEX = 1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // timers and compare values, same clock
    input wire occ_timing_t timing,
    // system state, same clock
    input wire logic cpu_idle,
    input wire logic gpio_level,
    // pins
    input wire logic fault_input,
    output logic compare_output_pin,
    // events
    output logic irq,
    output logic dma_request
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    occ_ctrl_t ctrl;
    logic [OCC_ST_WIDTH-1:0] status;
    logic [OCC_ST_WIDTH-1:0] mask;
    logic [OCC_ST_WIDTH-1:0] next_status;
    occ_pulse_t pulse_state;
    occ_pulse_t next_pulse_state;
    logic [15:0] duty;
    logic [15:0] next_duty;
    logic next_pin;
    logic next_fault_flag;
    logic fault_sync;
    logic fault_prev;
    logic fault_fall;
    logic [15:0] count;
    logic match_pri;
    logic match_sec;
    logic match_duty;
    logic rollover;
    logic halted;
    logic pin_rise;
    logic pin_fall;
    logic edge_event;
    logic fault_event;
    logic dp_write;
    logic [7:0] dp_addr;
    logic addr_phase;
    logic wr_ctrl;
    occ_mode_t new_mode;

    ////////////////////////////////////////////////////////////////////////
    // fault pin synchroniser and edge detect

    occ_sync #(
        .WIDTH(1)
    ) u_fault_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(fault_input),
        .sync_out(fault_sync)
    );

    // reset low like the synchroniser, so the idle-high pin gives no false fall after release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_prev <= 1'b0;
        end else begin
            fault_prev <= fault_sync;
        end
    end

    assign fault_fall = fault_prev & ~fault_sync;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always okay

    assign addr_phase = hsel & hready & htrans[1];
    assign wr_ctrl = dp_write & (dp_addr == OCC_ADDR_CTRL);
    assign new_mode = occ_mode_t'(hwdata[OCC_MODE_LSB +: 3]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= addr_phase & hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read data is fetched in the address phase so it stands for the whole data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= 32'h00000000;
            case (haddr[7:0])
                OCC_ADDR_CTRL: begin
                    hrdata[OCC_BIT_IDLE_STOP] <= ctrl.idle_stop;
                    hrdata[OCC_BIT_FAULT_FLAG] <= ctrl.fault_flag;
                    hrdata[OCC_BIT_TSEL] <= ctrl.timebase_select;
                    hrdata[OCC_MODE_LSB +: 3] <= ctrl.compare_mode;
                end
                OCC_ADDR_STATUS: begin
                    hrdata[OCC_ST_WIDTH-1:0] <= status;
                end
                OCC_ADDR_MASK: begin
                    hrdata[OCC_ST_WIDTH-1:0] <= mask;
                end
                default: begin
                    hrdata <= 32'h00000000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and mask registers

    // the timer should be stopped around this write; a match in the same cycle is dropped
    // one process owns the whole control struct, fault flag included
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl.idle_stop <= 1'b0;
            ctrl.fault_flag <= 1'b0;
            ctrl.timebase_select <= 1'b0;
            ctrl.compare_mode <= OCC_MODE_OFF;
        end else begin
            ctrl.fault_flag <= next_fault_flag;
            if (wr_ctrl) begin
                ctrl.idle_stop <= hwdata[OCC_BIT_IDLE_STOP];
                ctrl.timebase_select <= hwdata[OCC_BIT_TSEL];
                ctrl.compare_mode <= new_mode;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= OCC_MASK_RESET;
        end else if (dp_write && dp_addr == OCC_ADDR_MASK) begin
            mask <= hwdata[OCC_ST_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare path

    assign count = ctrl.timebase_select ? timing.timebase_b : timing.timebase_a;
    assign match_pri = (count == timing.primary_compare_value);
    assign match_sec = (count == timing.secondary_compare_value);
    assign match_duty = (count == duty);
    assign rollover = (count == OCC_COUNT_ZERO);
    assign halted = ctrl.idle_stop & cpu_idle;

    ////////////////////////////////////////////////////////////////////////
    // waveform generator

    always_comb begin
        next_pin = compare_output_pin;
        next_pulse_state = pulse_state;
        next_duty = duty;
        next_fault_flag = ctrl.fault_flag;
        fault_event = 1'b0;
        if (wr_ctrl) begin
            // entering a mode sets the initial pin level
            next_pulse_state = OCC_PS_ARM;
            // a fault arriving with the write still sets the flag
            if (ctrl.compare_mode == OCC_MODE_PWM_FAULT && fault_fall && !ctrl.fault_flag) begin
                fault_event = 1'b1;
                next_fault_flag = 1'b1;
            end else begin
                next_fault_flag = 1'b0;
            end
            next_duty = timing.primary_compare_value;
            case (new_mode)
                OCC_MODE_OFF: next_pin = gpio_level;
                OCC_MODE_SET_HIGH: next_pin = 1'b0;
                OCC_MODE_SET_LOW: next_pin = 1'b1;
                OCC_MODE_TOGGLE: next_pin = compare_output_pin;
                OCC_MODE_SINGLE_PULSE: next_pin = 1'b0;
                OCC_MODE_CONT_PULSE: next_pin = 1'b0;
                OCC_MODE_PWM: next_pin = (timing.primary_compare_value != OCC_COUNT_ZERO);
                OCC_MODE_PWM_FAULT: next_pin = (timing.primary_compare_value != OCC_COUNT_ZERO);
                default: next_pin = 1'b0;
            endcase
        end else if (ctrl.compare_mode == OCC_MODE_OFF) begin
            next_pin = gpio_level;
        end else if (!halted) begin
            case (ctrl.compare_mode)
                OCC_MODE_SET_HIGH: begin
                    if (match_pri) next_pin = 1'b1;
                end
                OCC_MODE_SET_LOW: begin
                    if (match_pri) next_pin = 1'b0;
                end
                OCC_MODE_TOGGLE: begin
                    if (match_pri) next_pin = ~compare_output_pin;
                end
                OCC_MODE_SINGLE_PULSE, OCC_MODE_CONT_PULSE: begin
                    case (pulse_state)
                        OCC_PS_ARM: begin
                            if (match_pri) begin
                                next_pin = 1'b1;
                                next_pulse_state = OCC_PS_HIGH;
                            end
                        end
                        OCC_PS_HIGH: begin
                            if (match_sec) begin
                                next_pin = 1'b0;
                                // single pulse stops here; continuous re-arms
                                if (ctrl.compare_mode == OCC_MODE_CONT_PULSE) begin
                                    next_pulse_state = OCC_PS_ARM;
                                end else begin
                                    next_pulse_state = OCC_PS_DONE;
                                end
                            end
                        end
                        OCC_PS_DONE: begin
                            next_pin = 1'b0;
                        end
                        default: begin
                            next_pulse_state = OCC_PS_ARM;
                        end
                    endcase
                end
                OCC_MODE_PWM, OCC_MODE_PWM_FAULT: begin
                    if (ctrl.compare_mode == OCC_MODE_PWM_FAULT && fault_fall && !ctrl.fault_flag) begin
                        fault_event = 1'b1;
                        next_fault_flag = 1'b1;
                    end
                    if (next_fault_flag) begin
                        // pin stays low until the mode is written again
                        next_pin = 1'b0;
                    end else if (rollover) begin
                        next_duty = timing.secondary_compare_value;
                        next_pin = (timing.secondary_compare_value != OCC_COUNT_ZERO);
                    end else if (match_duty) begin
                        next_pin = 1'b0;
                    end
                end
                default: begin
                    next_pin = compare_output_pin;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_output_pin <= 1'b0;
            pulse_state <= OCC_PS_ARM;
            duty <= OCC_COUNT_ZERO;
        end else begin
            compare_output_pin <= next_pin;
            pulse_state <= next_pulse_state;
            duty <= next_duty;
        end
    end


    ////////////////////////////////////////////////////////////////////////
    // interrupt events

    assign pin_rise = next_pin & ~compare_output_pin;
    assign pin_fall = ~next_pin & compare_output_pin;

    // mode entry changes the pin too, but that is not a compare event
    always_comb begin
        edge_event = 1'b0;
        if (!wr_ctrl) begin
            case (ctrl.compare_mode)
                OCC_MODE_SET_HIGH: edge_event = pin_rise;
                OCC_MODE_SET_LOW: edge_event = pin_fall;
                OCC_MODE_TOGGLE: edge_event = pin_rise | pin_fall;
                OCC_MODE_SINGLE_PULSE: edge_event = pin_fall;
                OCC_MODE_CONT_PULSE: edge_event = pin_fall;
                default: edge_event = 1'b0;
            endcase
        end
    end

    // a set in the same cycle as the clearing read wins
    always_comb begin
        next_status = status;
        if (addr_phase && !hwrite && haddr[7:0] == OCC_ADDR_STATUS) begin
            next_status = '0;
        end
        if (edge_event) next_status[OCC_ST_EDGE] = 1'b1;
        if (fault_event) next_status[OCC_ST_FAULT] = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & mask);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_request <= 1'b0;
        end else begin
            dma_request <= edge_event && CHANNEL_INDEX >= OCC_DMA_CH_FIRST
                           && CHANNEL_INDEX <= OCC_DMA_CH_LAST;
        end
    end

endmodule : occ_channel

// ===== tb/occ_channel_monitor.sv
`timescale 1ns/10ps
module occ_channel_monitor
    import occ_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // channel
    input wire occ_timing_t timing,
    input wire logic cpu_idle,
    input wire logic gpio_level,
    input wire logic fault_input,
    input wire logic compare_output_pin,
    input wire logic irq,
    input wire logic dma_request
);
    logic ap_wr;
    logic [7:0] ap_a;
    logic [2:0] md;
    logic tsel;
    logic stop;
    logic msk;
    logic [1:0] up;
    ////////////////////////////////////////////////////////////////
    // shadow of control and mask, rebuilt from bus writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr <= 1'b0;
            ap_a <= 8'h00;
        end else begin
            ap_wr <= hsel && hready && htrans[1] && hwrite;
            ap_a <= haddr[7:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {stop, tsel, md} <= 5'h00;
        end else if (ap_wr && ap_a == OCC_ADDR_CTRL) begin
            {stop, tsel, md} <= {hwdata[13], hwdata[3:0]};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msk <= 1'b0;
        end else if (ap_wr && ap_a == OCC_ADDR_MASK) begin
            msk <= hwdata[OCC_ST_EDGE];
        end
    end
    // the pin has not caught up with gpio on the first edges after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_mode(m);
        md == m && $past(md) == m;
    endsequence
    sequence s_fault;
        $fell(fault_input) && md == 3'h7;
    endsequence
    off_follow_a: assert property (s_mode(3'h0) and (up == 2'h3 && $stable(gpio_level))
        |-> compare_output_pin == gpio_level) else $error("pin not following gpio");
    rise_only_a: assert property (s_mode(3'h1) ##0 dma_request |-> $rose(compare_output_pin))
        else $error("event without rising pin");
    fall_only_a: assert property (md inside {3'h2, 3'h4, 3'h5} && dma_request
        |-> $fell(compare_output_pin)) else $error("event without falling pin");
    toggle_edge_a: assert property (s_mode(3'h3) |-> dma_request == $changed(compare_output_pin))
        else $error("toggle edge and event disagree");
    pwm_quiet_a: assert property (md == 3'h6 |-> !dma_request) else $error("event in plain pwm");
    fault_low_a: assert property (s_fault |-> ##[1:6] !compare_output_pin)
        else $error("fault did not drive pin low");
    event_irq_a: assert property (dma_request && msk && md != 3'h7 |=> irq)
        else $error("unmasked event without irq");
    select_base_a: assert property (s_mode(3'h1) ##0 $rose(compare_output_pin)
        |-> $past(tsel ? timing.timebase_b : timing.timebase_a) == $past(timing.primary_compare_value))
        else $error("rise without match on selected base");
    idle_hold_a: assert property (stop && cpu_idle && $past(stop && cpu_idle) && $past(md) == md
        |-> $stable(compare_output_pin)) else $error("pin moved in idle stop");
endmodule : occ_channel_monitor

bind occ_channel occ_channel_monitor mon_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .timing(timing), .cpu_idle(cpu_idle),
    .gpio_level(gpio_level), .fault_input(fault_input), .compare_output_pin(compare_output_pin),
    .irq(irq), .dma_request(dma_request)
);

// ===== tb/occ_load_model.sv
`timescale 1ns/10ps
module occ_load_model (
    // clock
    input wire logic hclk,
    // pins
    input wire logic compare_output_pin,
    input wire logic fault_req,
    output logic fault_input,
    // observation
    output logic [7:0] edge_count
);
    logic last_level = 1'b0;
    logic [7:0] cnt = 8'h00;
    // fault line is pulled up; the fault source only ever pulls it low
    assign fault_input = !fault_req;
    assign edge_count = cnt;
    always @(posedge hclk) begin
        last_level <= compare_output_pin;
        if (compare_output_pin !== last_level) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : occ_load_model

// ===== tb/test_output_compare_channel.sv
`timescale 1ns/10ps
module test_output_compare_channel;
    import occ_pkg::*;
    localparam logic [15:0] PRI = 16'h0010;
    localparam logic [15:0] SEC = 16'h0020;
    localparam logic [15:0] REST = 16'h0100;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    occ_timing_t timing = {REST, REST, PRI, SEC};
    logic cpu_idle = 1'b0;
    logic gpio_level = 1'b0;
    logic fault_req = 1'b0;
    logic fault_input;
    logic pin;
    logic irq;
    logic dma;
    logic [7:0] edges;
    logic [31:0] rdat;
    logic [7:0] dma_cnt = 8'h00;
    int err_total = 0;
    int comparisons = 0;
    occ_channel dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .timing(timing), .cpu_idle(cpu_idle), .gpio_level(gpio_level),
        .fault_input(fault_input), .compare_output_pin(pin), .irq(irq), .dma_request(dma)
    );
    occ_load_model load_u (
        .hclk(hclk), .compare_output_pin(pin), .fault_req(fault_req), .fault_input(fault_input),
        .edge_count(edges)
    );
    // the request is a one-cycle pulse, so the bench counts it as it goes by
    always @(posedge hclk) begin
        if (dma === 1'b1) begin
            dma_cnt <= dma_cnt + 8'h01;
        end
    end
    initial begin
        forever #20 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // single word transfer; waits on hready rather than assuming zero wait states
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
        #1;
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd_chk
    // one cycle of match, then counts park away from every compare value
    task automatic hit(input logic [15:0] a, input logic [15:0] b);
        @(posedge hclk);
        timing.timebase_a <= a;
        timing.timebase_b <= b;
        @(posedge hclk);
        timing.timebase_a <= REST;
        timing.timebase_b <= REST;
        repeat (2) @(posedge hclk);
        #1;
    endtask : hit
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({irq, pin, dma}, 3'h0);
        rd_chk(OCC_ADDR_CTRL, 32'h0);
        rd_chk(OCC_ADDR_STATUS, 32'h0);
        rd_chk(OCC_ADDR_MASK, 32'h0);
        rd_chk(8'h0C, 32'h0);
        chk({hreadyout, hresp}, 2'h2);
    endtask : t_reset
    task automatic t_shot();
        bus(1'b1, OCC_ADDR_MASK, 32'h1);
        bus(1'b1, OCC_ADDR_CTRL, 32'h1);
        chk(pin, 1'b0);
        hit(REST, PRI);
        chk(pin, 1'b0);
        hit(PRI, REST);
        chk({pin, irq}, 2'h3);
        rd_chk(OCC_ADDR_STATUS, 32'h1);
        chk(irq, 1'b0);
        bus(1'b1, OCC_ADDR_CTRL, 32'hA);
        chk(pin, 1'b1);
        hit(PRI, REST);
        chk(pin, 1'b1);
        hit(REST, PRI);
        chk({pin, irq}, 2'h1);
        rd_chk(OCC_ADDR_STATUS, 32'h1);
    endtask : t_shot
    task automatic t_toggle();
        logic [7:0] n;
        logic [7:0] k;
        bus(1'b1, OCC_ADDR_MASK, 32'h0);
        bus(1'b1, OCC_ADDR_CTRL, 32'h2);
        bus(1'b1, OCC_ADDR_CTRL, 32'h3);
        chk(pin, 1'b1);
        n = edges;
        k = dma_cnt;
        hit(PRI, REST);
        hit(PRI, REST);
        chk({pin, irq}, 2'h2);
        chk(edges - n, 8'h2);
        chk(dma_cnt - k, 8'h2);
        rd_chk(OCC_ADDR_STATUS, 32'h1);
    endtask : t_toggle
    task automatic t_pulse();
        bus(1'b1, OCC_ADDR_MASK, 32'h1);
        for (int m = 4; m <= 5; m++) begin
            bus(1'b1, OCC_ADDR_CTRL, m);
            chk(pin, 1'b0);
            hit(PRI, REST);
            chk({pin, irq}, 2'h2);
            hit(SEC, REST);
            chk({pin, irq}, 2'h1);
            rd_chk(OCC_ADDR_STATUS, 32'h1);
            hit(PRI, REST);
            chk(pin, m == 5);
        end
    endtask : t_pulse
    task automatic t_pwm();
        bus(1'b1, OCC_ADDR_CTRL, 32'h6);
        chk(pin, 1'b1);
        hit(PRI, REST);
        chk(pin, 1'b0);
        hit(16'h0000, REST);
        chk(pin, 1'b1);
        hit(SEC, REST);
        chk(pin, 1'b0);
        rd_chk(OCC_ADDR_STATUS, 32'h0);
        timing.primary_compare_value <= 16'h0000;
        bus(1'b1, OCC_ADDR_CTRL, 32'h6);
        chk(pin, 1'b0);
        timing.primary_compare_value <= PRI;
    endtask : t_pwm
    task automatic t_fault();
        bus(1'b1, OCC_ADDR_MASK, 32'h2);
        bus(1'b1, OCC_ADDR_CTRL, 32'h7);
        chk(pin, 1'b1);
        @(posedge hclk);
        fault_req <= 1'b1;
        repeat (8) @(posedge hclk);
        fault_req <= 1'b0;
        #1;
        chk({pin, irq}, 2'h1);
        rd_chk(OCC_ADDR_CTRL, 32'h17);
        rd_chk(OCC_ADDR_STATUS, 32'h2);
        bus(1'b1, OCC_ADDR_CTRL, 32'h13);
        rd_chk(OCC_ADDR_CTRL, 32'h3);
    endtask : t_fault
    task automatic t_idle();
        bus(1'b1, OCC_ADDR_CTRL, 32'h0);
        for (int g = 1; g >= 0; g--) begin
            gpio_level <= g[0];
            repeat (2) @(posedge hclk);
            #1;
            chk(pin, g[0]);
        end
        bus(1'b1, OCC_ADDR_CTRL, 32'h2001);
        cpu_idle <= 1'b1;
        hit(PRI, REST);
        chk(pin, 1'b0);
        bus(1'b1, OCC_ADDR_CTRL, 32'h1);
        hit(PRI, REST);
        chk(pin, 1'b1);
        cpu_idle <= 1'b0;
    endtask : t_idle
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_shot();
        t_toggle();
        t_pulse();
        t_pwm();
        t_fault();
        t_idle();
        finish_test();
    end
    // the sequence needs well under a thousand cycles; this allows about five thousand
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule : test_output_compare_channel
